/* File: hw/dual_port_block_ram.sv */
// What this block does
// - two ports share one 18432-bit array
// - each port acts on its own clock
// - widths 1,2,4,9,18,36; address 14 to 9
// - 9/18/36 split into data plus parity
// - no parity at widths 4, 2, 1
// - address lines are 14 minus log2 width
// - wide read joins consecutive narrow words
// - narrow read splits a wide word
// - each parity bit stays with its byte
// - dual-port or port A only
// - data written on one port readable on other
// - contents, defaults, widths, modes fixed at build
// - gate and strobe store data and parity
// - gate without strobe reads location
// - write mode picks output during write
// - controls active high, optional inversion
//
// Implementation choices: the register addresses and the address-and-strobe port.
module dual_port_block_ram
    import dp_ram_pkg::*;
#(
    parameter int             WIDTH_A   = 36,
    parameter int             WIDTH_B   = 36,
    parameter bit             SINGLE_PORT = 1'b0,
    parameter write_mode_type MODE_A    = mode_new_data,
    parameter write_mode_type MODE_B    = mode_new_data,
    parameter logic [3:0]     INVERT_A  = 4'h0,
    parameter logic [3:0]     INVERT_B  = 4'h0,
    parameter logic [35:0]    DEFAULT_A = 36'h0_0000_0000,
    parameter logic [35:0]    DEFAULT_B = 36'h0_0000_0000,
    parameter logic [16383:0] INIT_DATA = '0,
    parameter logic [2047:0]  INIT_PAR  = '0
)
(
    // system
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // port a
    input  wire logic        port_clk_a_i,
    input  wire logic        port_gate_a_i,
    input  wire logic        write_strobe_a_i,
    input  wire logic        output_sync_preset_a_i,
    input  wire logic [13:0] address_a_i,
    input  wire logic [31:0] write_data_bus_a_i,
    input  wire logic [3:0]  write_parity_bus_a_i,
    output logic      [31:0] read_data_bus_a_o,
    output logic      [3:0]  read_parity_bus_a_o,
    // port b
    input  wire logic        port_clk_b_i,
    input  wire logic        port_gate_b_i,
    input  wire logic        write_strobe_b_i,
    input  wire logic        output_sync_preset_b_i,
    input  wire logic [13:0] address_b_i,
    input  wire logic [31:0] write_data_bus_b_i,
    input  wire logic [3:0]  write_parity_bus_b_i,
    output logic      [31:0] read_data_bus_b_o,
    output logic      [3:0]  read_parity_bus_b_o
);

    // =========================================
    // build-time settings per port
    // per-port width
    localparam int             WID [0:1] = '{WIDTH_A, WIDTH_B};
    localparam write_mode_type MODE[0:1] = '{MODE_A, MODE_B};
    localparam logic [3:0]     INV [0:1] = '{INVERT_A, INVERT_B};
    localparam logic [35:0]    DEF [0:1] = '{DEFAULT_A, DEFAULT_B};

    logic              mem_data [0:DATA_BITS-1];
    logic              mem_par  [0:PAR_BITS-1];
    logic [PK_W-1:0]   raw      [0:1];
    logic [PK_W-1:0]   sync1    [0:1];
    logic [PK_W-1:0]   sync2    [0:1];
    logic [PK_W-1:0]   sync3    [0:1];
    logic              edge_hit [0:1];
    logic              gate     [0:1];
    logic              wr       [0:1];
    logic              preset   [0:1];
    logic [13:0]       addr     [0:1];
    logic [35:0]       wr_word  [0:1];
    logic [35:0]       rd_word  [0:1];
    logic [35:0]       dout     [0:1];

    // =========================================
    // index arithmetic
    // parity per byte
    function automatic logic [13:0] bit_index(
        input logic [13:0] a, input int w, input int i);
        int word;
        word = int'(a) & ((1 << addr_width(w)) - 1);
        return 14'(word * data_width(w) + i);
    endfunction

    function automatic logic [10:0] par_index(
        input logic [13:0] a, input int w, input int j);
        int word;
        word = int'(a) & ((1 << addr_width(w)) - 1);
        return 11'(word * parity_width(w) + j);
    endfunction

    function automatic logic [35:0] fit(input logic [35:0] v, input int w);
        logic [35:0] r;
        r = '0;
        for (int i = 0; i < DATA_MAX; i++)
            if (i < data_width(w))
                r[i] = v[i];
        for (int j = 0; j < PAR_MAX; j++)
            if (j < parity_width(w))
                r[DATA_MAX+j] = v[DATA_MAX+j];
        return r;
    endfunction

    function automatic logic [35:0] read_at(
        input logic [13:0] a, input int w);
        logic [35:0] r;
        r = '0;
        for (int i = 0; i < DATA_MAX; i++)
            if (i < data_width(w))
                r[i] = mem_data[bit_index(a, w, i)];
        for (int j = 0; j < PAR_MAX; j++)
            if (j < parity_width(w))
                r[DATA_MAX+j] = mem_par[par_index(a, w, j)];
        return r;
    endfunction

    // port a location as port b sees it; only for a no wider than b
    function automatic logic [35:0] via_b(input logic [13:0] a);
        logic [35:0] b_word;
        logic [35:0] r;
        int          s;
        int          k;
        int          o;
        s = int'(bit_index(a, WIDTH_A, 0));
        k = s % data_width(WIDTH_B);
        o = k * parity_width(WIDTH_A) / data_width(WIDTH_A);
        b_word = read_at(14'(s / data_width(WIDTH_B)), WIDTH_B);
        r = '0;
        for (int i = 0; i < DATA_MAX; i++)
            if (i < data_width(WIDTH_A))
                r[i] = b_word[k+i];
        for (int j = 0; j < PAR_MAX; j++)
            if (j < parity_width(WIDTH_A))
                r[DATA_MAX+j] = b_word[DATA_MAX+o+j];
        return r;
    endfunction

    // =========================================
    // port sampling
    assign raw[0] = {port_clk_a_i, write_strobe_a_i, port_gate_a_i,
                     output_sync_preset_a_i, address_a_i,
                     write_data_bus_a_i, write_parity_bus_a_i};
    assign raw[1] = {port_clk_b_i, write_strobe_b_i, port_gate_b_i,
                     output_sync_preset_b_i, address_b_i,
                     write_data_bus_b_i, write_parity_bus_b_i};

    // third stage keeps the sample taken before the clock rose,
    // so data changed right after the port edge is not seen
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                sync1[p] <= '0;
                sync2[p] <= '0;
                sync3[p] <= '0;
            end
        end
        else
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                sync1[p] <= raw[p];
                sync2[p] <= sync1[p];
                sync3[p] <= sync2[p];
            end
        end
    end

    always_comb
    begin
        for (int p = 0; p < PORTS; p++)
        begin
            edge_hit[p] = (sync2[p][PK_CLK] ^ INV[p][INV_CLK])
                        & ~(sync3[p][PK_CLK] ^ INV[p][INV_CLK]);
            if (p == 1 && SINGLE_PORT)
                edge_hit[p] = 1'b0;
            gate[p]   = sync3[p][PK_EN] ^ INV[p][INV_EN];
            preset[p] = sync3[p][PK_PRESET] ^ INV[p][INV_PRESET];
            wr[p]     = edge_hit[p] & gate[p]
                      & (sync3[p][PK_WE] ^ INV[p][INV_WE]);
            addr[p]   = sync3[p][PK_ADDR+:ADDR_MAX];
            wr_word[p] = fit({sync3[p][PK_PAR+:PAR_MAX],
                              sync3[p][PK_DATA+:DATA_MAX]}, WID[p]);
            rd_word[p] = read_at(addr[p], WID[p]);
        end
    end

    // =========================================
    // storage
    // one array shared; port b wins a same-cycle clash
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int i = 0; i < DATA_BITS; i++)
                mem_data[i] <= INIT_DATA[i];
            for (int i = 0; i < PAR_BITS; i++)
                mem_par[i] <= INIT_PAR[i];
        end
        else
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                if (wr[p])
                begin
                    for (int i = 0; i < DATA_MAX; i++)
                        if (i < data_width(WID[p]))
                            mem_data[bit_index(addr[p], WID[p], i)]
                                <= wr_word[p][i];
                    for (int j = 0; j < PAR_MAX; j++)
                        if (j < parity_width(WID[p]))
                            mem_par[par_index(addr[p], WID[p], j)]
                                <= wr_word[p][DATA_MAX+j];
                end
            end
        end
    end

    // =========================================
    // output registers
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dout[0] <= fit(DEFAULT_A, WIDTH_A);
            dout[1] <= fit(DEFAULT_B, WIDTH_B);
        end
        else
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                if (edge_hit[p] && gate[p])
                begin
                    if (preset[p])
                        dout[p] <= fit(DEF[p], WID[p]);
                    else if (wr[p])
                    begin
                        case (MODE[p])
                            mode_new_data: dout[p] <= wr_word[p];
                            mode_old_data: dout[p] <= rd_word[p];
                            mode_hold:     dout[p] <= dout[p];
                            default:       dout[p] <= dout[p];
                        endcase
                    end
                    else
                        dout[p] <= rd_word[p];
                end
            end
        end
    end

    assign read_data_bus_a_o   = dout[0][DATA_MAX-1:0];
    assign read_parity_bus_a_o = dout[0][WORD_MAX-1:DATA_MAX];
    assign read_data_bus_b_o   = dout[1][DATA_MAX-1:0];
    assign read_parity_bus_b_o = dout[1][WORD_MAX-1:DATA_MAX];

    // =========================================
    // checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_idle_out_hold: assert property (
        !(edge_hit[0] && gate[0]) |=> $stable(dout[0]))
        else $error("port a output moved without gated edge");

    a_plain_read: assert property (
        edge_hit[1] && gate[1] && !wr[1] && !preset[1]
        |=> dout[1] == $past(rd_word[1]))
        else $error("port b read returned wrong word");

    a_write_stored: assert property (
        wr[0] && !wr[1]
        |=> read_at($past(addr[0]), WIDTH_A) == $past(wr_word[0]))
        else $error("port a write not stored");

    a_new_data_out: assert property (
        MODE_B == mode_new_data && wr[1] && !preset[1]
        |=> dout[1] == $past(wr_word[1]))
        else $error("new-data mode output wrong");

    a_old_data_out: assert property (
        MODE_A == mode_old_data && wr[0] && !preset[0]
        |=> dout[0] == $past(rd_word[0]))
        else $error("old-data mode output wrong");

    a_hold_mode_out: assert property (
        MODE_A == mode_hold && wr[0] && !preset[0]
        |=> $stable(dout[0]))
        else $error("hold mode output changed");

    a_preset_value: assert property (
        edge_hit[0] && gate[0] && preset[0]
        |=> dout[0] == fit(DEFAULT_A, WIDTH_A))
        else $error("preset did not load default");

    a_width_mask: assert property (
        dout[0] == fit(dout[0], WIDTH_A) && dout[1] == fit(dout[1], WIDTH_B))
        else $error("output bits beyond port width");

    a_single_port: assert property (
        SINGLE_PORT |-> dout[1] == fit(DEFAULT_B, WIDTH_B))
        else $error("port b active in single-port build");

    a_cross_port: assert property (
        wr[0] && !wr[1] && data_width(WIDTH_A) <= data_width(WIDTH_B)
        |=> via_b($past(addr[0])) == $past(wr_word[0]))
        else $error("port a write not seen through port b");
endmodule

/* File: hw/dp_ram_pkg.sv */
package dp_ram_pkg;
    // =========================================
    // array size
    localparam int DATA_BITS = 16384;
    localparam int PAR_BITS  = 2048;
    localparam int ADDR_MAX  = 14;
    localparam int DATA_MAX  = 32;
    localparam int PAR_MAX   = 4;
    localparam int WORD_MAX  = DATA_MAX + PAR_MAX;
    localparam int PORTS     = 2;

    // =========================================
    // packed port sample: {clk, we, en, preset, addr, data, par}
    localparam int PK_PAR    = 0;
    localparam int PK_DATA   = PK_PAR + PAR_MAX;
    localparam int PK_ADDR   = PK_DATA + DATA_MAX;
    localparam int PK_PRESET = PK_ADDR + ADDR_MAX;
    localparam int PK_EN     = PK_PRESET + 1;
    localparam int PK_WE     = PK_EN + 1;
    localparam int PK_CLK    = PK_WE + 1;
    localparam int PK_W      = PK_CLK + 1;

    // =========================================
    // polarity inversion bits
    localparam int INV_CLK    = 0;
    localparam int INV_WE     = 1;
    localparam int INV_EN     = 2;
    localparam int INV_PRESET = 3;

    typedef enum logic [1:0]
    {
        mode_new_data,
        mode_old_data,
        mode_hold
    } write_mode_type;

    // =========================================
    // aspect ratio decode
    function automatic int parity_width(input int w);
        return (w == 36) ? 4 : (w == 18) ? 2 : (w == 9) ? 1 : 0;
    endfunction

    function automatic int data_width(input int w);
        return w - parity_width(w);
    endfunction

    function automatic int width_log2(input int w);
        return $clog2(data_width(w));
    endfunction

    function automatic int addr_width(input int w);
        return ADDR_MAX - width_log2(w);
    endfunction
endpackage

/* File: tb/port_user.sv */
// =========================================
// fabric logic that drives one ram port
module port_user
    import dp_ram_pkg::*;
(
    // system
    input  wire logic        clk_i,
    // port pins
    output logic             port_clk_o,
    output logic             gate_o,
    output logic             strobe_o,
    output logic             preset_o,
    output logic      [13:0] addr_o,
    output logic      [31:0] data_o,
    output logic      [3:0]  par_o,
    // result ready for the bench
    output logic             done_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {port_clk_o, gate_o, strobe_o, preset_o, done_o} = 5'h00;
        addr_o = 14'h0_000;
        {par_o, data_o} = 36'h0_0000_0000;
    end

    task automatic op(input logic g, w, p, input logic [13:0] a,
                      input logic [35:0] d);
        @(posedge clk_i);
        gate_o <= g;
        strobe_o <= w;
        preset_o <= p;
        addr_o <= a;
        {par_o, data_o} <= d;
        repeat (2) @(posedge clk_i);
        port_clk_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        port_clk_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        done_o <= g;
        @(posedge clk_i);
        done_o <= 1'b0;
        // strobe, address and data turn over and gate and preset drop, so stale values never look valid
        gate_o <= 1'b0;
        strobe_o <= ~w;
        preset_o <= 1'b0;
        addr_o <= ~a;
        {par_o, data_o} <= ~d;
    endtask
endmodule

/* File: tb/dual_port_block_ram_bench.sv */
`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module dual_port_block_ram_bench import dp_ram_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [35:0] DEF_A = 36'h1_0000_00A5;
    localparam logic [35:0] DEF_B = 36'h9_1234_5678;
    // port a default cut to four data bits, no parity
    localparam logic [35:0] DEF_C = 36'h0_0000_0005;

    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic a_clk, a_gate, a_we, a_pre, a_done, b_clk, b_gate, b_we, b_pre, b_done;
    logic [13:0] a_addr, b_addr;
    logic [31:0] a_data, b_data, rd_a, rd_b;
    logic [3:0] a_par, b_par, rp_a, rp_b;
    logic [16383:0] sd = '0;
    logic [2047:0] sp = '0;
    logic [35:0] qa[$], qb[$], ea, eb, last_a, t;
    logic [8:0] kb;
    logic c_clk, c_gate, c_we, c_pre, c_done;
    logic [13:0] c_addr;
    logic [31:0] c_data, rd_c, rd_d;
    logic [3:0] c_par, rp_c, rp_d;
    logic [16383:0] sc = '0;
    logic [35:0] qc[$], ec;
    logic [35:0] last_c = DEF_C;
    int n_fail = 0;
    int num_checks = 0;
    int seed = 66359;

    always #12.5 clk_i = ~clk_i;

    dual_port_block_ram #(.WIDTH_A(9), .WIDTH_B(36),
        .MODE_A(mode_old_data), .MODE_B(mode_new_data),
        .DEFAULT_A(DEF_A), .DEFAULT_B(DEF_B)) dual_port_block_ram_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i),
        .port_clk_a_i(a_clk), .port_gate_a_i(a_gate),
        .write_strobe_a_i(a_we), .output_sync_preset_a_i(a_pre),
        .address_a_i(a_addr), .write_data_bus_a_i(a_data),
        .write_parity_bus_a_i(a_par), .read_data_bus_a_o(rd_a),
        .read_parity_bus_a_o(rp_a),
        .port_clk_b_i(b_clk), .port_gate_b_i(b_gate),
        .write_strobe_b_i(b_we), .output_sync_preset_b_i(b_pre),
        .address_b_i(b_addr), .write_data_bus_b_i(b_data),
        .write_parity_bus_b_i(b_par), .read_data_bus_b_o(rd_b),
        .read_parity_bus_b_o(rp_b));

    port_user port_user_a_i (.clk_i(clk_i), .port_clk_o(a_clk),
        .gate_o(a_gate), .strobe_o(a_we), .preset_o(a_pre), .addr_o(a_addr),
        .data_o(a_data), .par_o(a_par), .done_o(a_done));
    port_user port_user_b_i (.clk_i(clk_i), .port_clk_o(b_clk),
        .gate_o(b_gate), .strobe_o(b_we), .preset_o(b_pre), .addr_o(b_addr),
        .data_o(b_data), .par_o(b_par), .done_o(b_done));
    port_user port_user_c_i (.clk_i(clk_i), .port_clk_o(c_clk),
        .gate_o(c_gate), .strobe_o(c_we), .preset_o(c_pre), .addr_o(c_addr),
        .data_o(c_data), .par_o(c_par), .done_o(c_done));

    // second build: narrow port a, inverted controls, port b absent
    dual_port_block_ram #(.WIDTH_A(4), .SINGLE_PORT(1'b1),
        .MODE_A(mode_hold), .INVERT_A(4'hf), .DEFAULT_A(DEF_A),
        .DEFAULT_B(DEF_B)) dual_port_block_ram_narrow_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i),
        .port_clk_a_i(~c_clk), .port_gate_a_i(~c_gate),
        .write_strobe_a_i(~c_we), .output_sync_preset_a_i(~c_pre),
        .address_a_i(c_addr), .write_data_bus_a_i(c_data),
        .write_parity_bus_a_i(c_par), .read_data_bus_a_o(rd_c),
        .read_parity_bus_a_o(rp_c),
        .port_clk_b_i(b_clk), .port_gate_b_i(b_gate),
        .write_strobe_b_i(b_we), .output_sync_preset_b_i(b_pre),
        .address_b_i(b_addr), .write_data_bus_b_i(b_data),
        .write_parity_bus_b_i(b_par), .read_data_bus_b_o(rd_d),
        .read_parity_bus_b_o(rp_d));

    // =========================================
    // shadow model
    function automatic logic [35:0] rnd();
        logic [63:0] v;
        v = {$random(seed), $random(seed)};
        return v[35:0];
    endfunction

    function automatic logic [35:0] exp_a(input logic [13:0] a);
        return {3'h0, sp[a[10:0]], 24'h00_0000, sd[a[10:0]*8 +: 8]};
    endfunction

    function automatic logic [35:0] exp_b(input logic [13:0] a);
        return {sp[a[8:0]*4 +: 4], sd[a[8:0]*32 +: 32]};
    endfunction

    task automatic a_op(input logic g, w, p, input logic [8:0] k,
                        input logic [1:0] i);
        logic [35:0] d, r;
        logic [13:0] a;
        d = rnd();
        r = rnd();
        a = {r[2:0], k, i};
        if (g)
            qa.push_back(p ? DEF_A : exp_a(a));
        if (g && w)
        begin
            sd[a[10:0]*8 +: 8] = d[7:0];
            sp[a[10:0]] = d[32];
        end
        port_user_a_i.op(g, w, p, a, d);
    endtask

    task automatic b_op(input logic g, w, p, input logic [8:0] k);
        logic [35:0] d, r;
        logic [13:0] a;
        d = rnd();
        r = rnd();
        a = {r[4:0], k};
        if (g && w)
        begin
            sd[k*32 +: 32] = d[31:0];
            sp[k*4 +: 4] = d[35:32];
        end
        if (g)
            qb.push_back(p ? DEF_B : exp_b(a));
        port_user_b_i.op(g, w, p, a, d);
    endtask

    // controls reach the pins inverted; port a holds on write
    task automatic c_op(input logic g, w, p, input logic [13:0] a);
        logic [35:0] d;
        d = rnd();
        if (g && p)
            last_c = DEF_C;
        else if (g && !w)
            last_c = {32'h0000_0000, sc[a[11:0]*4 +: 4]};
        if (g)
            qc.push_back(last_c);
        if (g && w)
            sc[a[11:0]*4 +: 4] = d[3:0];
        port_user_c_i.op(g, w, p, a, d);
    endtask

    // =========================================
    // result watcher
    always @(posedge clk_i)
    begin
        if (a_done)
        begin
            ea = qa.pop_front();
            last_a = {rp_a, rd_a};
            `CHK({rp_a, rd_a}, ea)
        end
        if (b_done)
        begin
            eb = qb.pop_front();
            `CHK({rp_b, rd_b}, eb)
            `CHK({rp_d, rd_d}, DEF_B)
        end
        if (c_done)
        begin
            ec = qc.pop_front();
            `CHK({rp_c, rd_c}, ec)
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ops take about 11 cycles; allow ample margin
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        end_of_test();
    end

    // =========================================
    // scenarios
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK({rp_a, rd_a}, DEF_A)
        `CHK({rp_b, rd_b}, DEF_B)
        `CHK({rp_c, rd_c}, DEF_C)
        `CHK({rp_d, rd_d}, DEF_B)
        for (int r = 0; r < 6; r++)
        begin
            t = rnd();
            kb = t[8:0];
            // narrow writes joined by wide read
            for (int i = 0; i < 4; i++)
                a_op(1'b1, 1'b1, 1'b0, kb, 2'(i));
            b_op(1'b1, 1'b0, 1'b0, kb);
            // wide write split by narrow reads
            b_op(1'b1, 1'b1, 1'b0, kb + 9'h001);
            for (int i = 0; i < 4; i++)
                a_op(1'b1, 1'b0, 1'b0, kb + 9'h001, 2'(i));
            a_op(1'b0, 1'b1, 1'b0, kb, 2'h0);
            `CHK({rp_a, rd_a}, last_a)
            a_op(1'b1, 1'b0, 1'b0, kb, 2'h0);
            fork
                a_op(1'b1, 1'b0, 1'b1, kb, 2'h1);
                b_op(1'b1, 1'b1, 1'b0, kb + 9'h002);
            join
            b_op(1'b1, 1'b0, 1'b1, kb);
            // hold write, read back, hold write, preset, read again
            t = rnd();
            c_op(1'b1, 1'b1, 1'b0, t[13:0]);
            c_op(1'b1, 1'b0, 1'b0, t[13:0]);
            c_op(1'b1, 1'b1, 1'b0, t[13:0]);
            c_op(1'b1, 1'b0, 1'b1, t[13:0]);
            c_op(1'b1, 1'b0, 1'b0, t[13:0]);
        end
        // a second reset reloads contents and defaults
        rst_b_i <= 1'b0;
        sd = '0;
        sp = '0;
        sc = '0;
        last_c = DEF_C;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK({rp_a, rd_a}, DEF_A)
        `CHK({rp_c, rd_c}, DEF_C)
        b_op(1'b1, 1'b0, 1'b0, kb);
        c_op(1'b1, 1'b0, 1'b0, t[13:0]);
        end_of_test();
    end
endmodule
